// File: logic/e1fes_top.sv
`timescale 1ns/100ps
module e1fes_top
	import e1fes_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        alignShiftEvent,
	input  wire logic        patternImitationEvent,
	input  wire logic        crc4ErrorEvent,
	input  wire logic        fasBitErrorEvent,
	input  wire logic        fasChecked,
	input  wire logic        fasErrored,
	input  wire logic        resyncDone,
	output logic             frameLossDefect,
	output logic             irqOut
);
	e1fes_reg_if regBus ();

	logic [7:0] framingCtrl_reg;
	logic [7:0] framingCtrl_next;
	logic [4:0] eventStatus_reg;
	logic [4:0] eventStatus_next;
	logic [4:0] eventEnable_reg;
	logic [4:0] eventEnable_next;
	logic [4:0] readMask_reg;
	logic [4:0] readMask_next;
	logic [4:0] eventHits;
	logic [4:0] rdStatus;
	logic       defectChange;
	logic       irq_reg;
	logic       irq_next;
	logic [7:0] rdMux;
	logic       hitMux;

	e1fes_apb_slave u_apb (
		.clk_sys (clk_sys),
		.rst     (rst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.bus     (regBus)
	);

	// framing state lives here, apart from the alignment-bit error flag
	e1fes_frame_monitor #(
		.CNT_W (E1FES_THRESH_W)
	) u_frame (
		.clk_sys         (clk_sys),
		.rst             (rst),
		.fasChecked      (fasChecked),
		.fasErrored      (fasErrored),
		.resyncDone      (resyncDone),
		.lossThreshold   (framingCtrl_reg[THRESH_LSB +: E1FES_THRESH_W]),
		.frameLossDefect (frameLossDefect),
		.defectChange    (defectChange)
	);

	// events gathered at their status bit positions
	always_comb begin
		eventHits                  = '0;
		eventHits[BIT_ALIGN_SHIFT] = alignShiftEvent;
		eventHits[BIT_FRAME_LOSS]  = defectChange;
		eventHits[BIT_IMITATION]   = patternImitationEvent;
		eventHits[BIT_CRC4_ERR]    = crc4ErrorEvent;
		eventHits[BIT_FAS_ERR]     = fasBitErrorEvent;
	end

	// read decode
	always_comb begin
		rdMux    = 8'h00;
		hitMux   = 1'b1;
		rdStatus = eventStatus_reg;
		case (regBus.idx)
			IDX_FRAMING_CTRL: rdMux = framingCtrl_reg;
			IDX_EVENT_STATUS: rdMux = {3'h0, rdStatus};
			IDX_EVENT_ENABLE: rdMux = {3'h0, eventEnable_reg};
			IDX_DEFECT_STATE: rdMux = {7'h00, frameLossDefect};
			default:          hitMux = 1'b0;
		endcase
	end

	assign regBus.rdData = rdMux;
	assign regBus.hit    = hitMux;

	// register state; only the bits shown to the reader are cleared by the read
	always_comb begin
		framingCtrl_next = framingCtrl_reg;
		eventEnable_next = eventEnable_reg;
		readMask_next    = readMask_reg;
		eventStatus_next = eventStatus_reg;
		if (regBus.setupRd && regBus.idx == IDX_EVENT_STATUS) begin
			readMask_next = eventStatus_reg;
		end
		if (regBus.accessRd && regBus.idx == IDX_EVENT_STATUS) begin
			eventStatus_next = eventStatus_reg & ~readMask_reg;
			readMask_next    = '0;
		end
		eventStatus_next = eventStatus_next | eventHits;
		if (regBus.accessWr) begin
			case (regBus.idx)
				IDX_FRAMING_CTRL: framingCtrl_next = regBus.wrData;
				IDX_EVENT_ENABLE: eventEnable_next = regBus.wrData[E1FES_EVENT_W-1:0];
				default:          framingCtrl_next = framingCtrl_reg;
			endcase
		end
		irq_next = |(eventStatus_reg & eventEnable_reg);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			framingCtrl_reg <= FRAMING_CTRL_RST;
			eventStatus_reg <= EVENT_STATUS_RST;
			eventEnable_reg <= EVENT_ENABLE_RST;
			readMask_reg    <= '0;
			irq_reg         <= 1'b0;
		end else begin
			framingCtrl_reg <= framingCtrl_next;
			eventStatus_reg <= eventStatus_next;
			eventEnable_reg <= eventEnable_next;
			readMask_reg    <= readMask_next;
			irq_reg         <= irq_next;
		end
	end

	assign irqOut = irq_reg;
endmodule

// File: inc/e1fes_pkg.sv
// Functional notes
// - set status bit 4 when the alignment signal appears shifted.
// - declare frame loss after threshold consecutive errored alignment patterns, field bits 2-0.
// - set status bit 3 on both declaration and clearing of frame loss.
// - set status bit 2 when payload imitates the framing pattern.
// - set status bit 1 on every failed CRC-4 sub-multiframe check.
// - set status bit 0 when alignment bits arrive in error.
// - alignment-bit error flag is kept apart from the framing state.
// - status bits report events since last read; the read clears them.
// - interrupt only for latched events whose enable bit is set.
// - all five status bits reset to zero.
// - enable register bit 4 is read-write, resets to zero, gates bit 4.
package e1fes_pkg;
	localparam int          E1FES_ADDR_W     = 16;
	localparam int          E1FES_IDX_W      = 12;
	localparam int          E1FES_REG_W      = 8;
	localparam int          E1FES_EVENT_W    = 5;
	localparam int          E1FES_THRESH_W   = 3;
	localparam int          E1FES_IDX_LSB    = 2;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_FRAMING_CTRL = 12'h10B;
	localparam logic [11:0] IDX_EVENT_STATUS = 12'hB04;
	localparam logic [11:0] IDX_EVENT_ENABLE = 12'hB05;
	localparam logic [11:0] IDX_DEFECT_STATE = 12'hB06;
	// status and enable bit positions
	localparam int          BIT_ALIGN_SHIFT  = 4;
	localparam int          BIT_FRAME_LOSS   = 3;
	localparam int          BIT_IMITATION    = 2;
	localparam int          BIT_CRC4_ERR     = 1;
	localparam int          BIT_FAS_ERR      = 0;
	localparam int          THRESH_LSB       = 0;
	// reset values
	localparam logic [7:0]  FRAMING_CTRL_RST = 8'h03;
	localparam logic [4:0]  EVENT_STATUS_RST = 5'h00;
	localparam logic [4:0]  EVENT_ENABLE_RST = 5'h00;

	typedef enum logic [1:0] {
		ST_IN_FRAME  = 2'b01,
		ST_OUT_FRAME = 2'b10
	} e1fes_frame_state_t;

	function automatic logic [E1FES_IDX_W-1:0] e1fes_index(input logic [E1FES_ADDR_W-1:0] addr);
		return addr[E1FES_IDX_LSB +: E1FES_IDX_W];
	endfunction
endpackage

// File: inc/e1fes_reg_if.sv
`timescale 1ns/100ps
interface e1fes_reg_if;
	logic [11:0] idx;
	logic [7:0]  wrData;
	logic        setupRd;
	logic        accessRd;
	logic        accessWr;
	logic [7:0]  rdData;
	logic        hit;
	modport slave (output idx, wrData, setupRd, accessRd, accessWr, input rdData, hit);
	modport regs  (input idx, wrData, setupRd, accessRd, accessWr, output rdData, hit);
endinterface

// File: logic/e1fes_apb_slave.sv
`timescale 1ns/100ps
module e1fes_apb_slave
	import e1fes_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	e1fes_reg_if.slave       bus
);
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        slverr_reg;
	logic        slverr_next;
	logic        setupPhase;
	logic        aligned;

	assign setupPhase   = psel & ~penable;
	assign aligned      = (paddr[1:0] == 2'h0);
	assign bus.idx      = e1fes_index(paddr);
	assign bus.wrData   = pwdata[E1FES_REG_W-1:0];
	assign bus.setupRd  = setupPhase & ~pwrite & aligned;
	assign bus.accessRd = psel & penable & ~pwrite & aligned & bus.hit;
	assign bus.accessWr = psel & penable & pwrite & aligned & bus.hit;
	assign pready       = 1'b1;
	assign prdata       = prdata_reg;
	assign pslverr      = slverr_reg;

	// answer is prepared in the setup cycle so the access cycle completes at once
	always_comb begin
		prdata_next = prdata_reg;
		slverr_next = slverr_reg;
		if (setupPhase) begin
			slverr_next = ~(aligned & bus.hit);
			prdata_next = 32'h0000_0000;
			if (~pwrite & aligned & bus.hit) begin
				prdata_next = {24'h00_0000, bus.rdData};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			slverr_reg <= slverr_next;
		end
	end
endmodule

// File: logic/e1fes_frame_monitor.sv
`timescale 1ns/100ps
module e1fes_frame_monitor
	import e1fes_pkg::*;
#(
	parameter int CNT_W = E1FES_THRESH_W
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             fasChecked,
	input  wire logic             fasErrored,
	input  wire logic             resyncDone,
	input  wire logic [CNT_W-1:0] lossThreshold,
	output logic                  frameLossDefect,
	output logic                  defectChange
);
	// refuse counter widths the threshold field and compare cannot serve
	if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
		$error("e1fes_frame_monitor: CNT_W must be 1 to 8");
	end

	e1fes_frame_state_t state_reg;
	e1fes_frame_state_t state_next;
	logic [CNT_W-1:0]   errCount_reg;
	logic [CNT_W-1:0]   errCount_next;
	logic               change_reg;
	logic               change_next;
	logic [CNT_W-1:0]   limit;

	// a zero threshold behaves as one errored pattern
	assign limit = (lossThreshold == '0) ? CNT_W'(1) : lossThreshold;
	assign frameLossDefect = (state_reg == ST_OUT_FRAME);
	assign defectChange    = change_reg;

	always_comb begin
		state_next    = state_reg;
		errCount_next = errCount_reg;
		change_next   = 1'b0;
		case (state_reg)
			ST_IN_FRAME: begin
				if (fasChecked && fasErrored) begin
					if (errCount_reg + CNT_W'(1) >= limit) begin
						state_next    = ST_OUT_FRAME;
						errCount_next = '0;
						change_next   = 1'b1;
					end else begin
						errCount_next = errCount_reg + CNT_W'(1);
					end
				end else if (fasChecked) begin
					errCount_next = '0;
				end
			end
			ST_OUT_FRAME: begin
				errCount_next = '0;
				if (resyncDone) begin
					state_next  = ST_IN_FRAME;
					change_next = 1'b1;
				end
			end
			default: begin
				state_next    = ST_IN_FRAME;
				errCount_next = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg    <= ST_IN_FRAME;
			errCount_reg <= '0;
			change_reg   <= 1'b0;
		end else begin
			state_reg    <= state_next;
			errCount_reg <= errCount_next;
			change_reg   <= change_next;
		end
	end
endmodule

// File: verif/e1fes_properties.sv
`timescale 1ns/100ps
module e1fes_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic alignShiftEvent,
	input wire logic patternImitationEvent,
	input wire logic crc4ErrorEvent,
	input wire logic fasBitErrorEvent,
	input wire logic fasChecked,
	input wire logic fasErrored,
	input wire logic resyncDone,
	input wire logic frameLossDefect,
	input wire logic irqOut
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic evAny;
	assign evAny = alignShiftEvent | patternImitationEvent | crc4ErrorEvent | fasBitErrorEvent;
	sequence sResync;
		frameLossDefect && resyncDone;
	endsequence
	chk_defect_cause: assert property ($rose(frameLossDefect) |-> $past(fasChecked && fasErrored))
		else $error("frame loss rose without errored pattern");
	chk_good_pattern: assert property (!frameLossDefect && fasChecked && !fasErrored |=> !frameLossDefect)
		else $error("frame loss after good pattern");
	chk_defect_exit: assert property (sResync |=> !frameLossDefect)
		else $error("frame loss kept after resync");
	chk_defect_hold: assert property (frameLossDefect && !resyncDone |=> frameLossDefect)
		else $error("frame loss cleared without resync");
	chk_fas_flag: assert property (!frameLossDefect && fasBitErrorEvent && !fasChecked |=> !frameLossDefect)
		else $error("bit error flag changed framing state");
	chk_irq_cause: assert property ($rose(irqOut) |-> $past(evAny, 2) ||
		$past(fasChecked || resyncDone, 3) || $past(psel && penable, 2))
		else $error("interrupt rose without cause");
	chk_irq_drop: assert property ($fell(irqOut) |-> $past(psel && penable, 2) || $past(rst))
		else $error("interrupt fell without access");
	chk_reset_clear: assert property ($past(rst) && !rst |-> !irqOut && !frameLossDefect)
		else $error("outputs not clear after reset");
endmodule
bind e1fes_top e1fes_properties u_props (.clk_sys, .rst, .psel, .penable, .alignShiftEvent,
	.patternImitationEvent, .crc4ErrorEvent, .fasBitErrorEvent, .fasChecked, .fasErrored,
	.resyncDone, .frameLossDefect, .irqOut);

// File: verif/e1fes_host_model.sv
`timescale 1ns/100ps
module e1fes_host_model (
	input  wire logic        clk_sys,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [15:0] paddr,
	output logic      [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
	end
	// one transfer: setup cycle, then access cycle held until pready is seen
	task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// File: verif/test_e1_rx_framer_event_status.sv
`timescale 1ns/100ps
module test_e1_rx_framer_event_status;
	import e1fes_pkg::*;
	logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, frameLossDefect, irqOut;
	logic fasChecked, fasErrored, resyncDone;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0] ev, m;
	logic [31:0] seed = 32'h5F2F;
	logic [31:0] expQ[$];
	logic        slvErrQ[$];
	int errTotal = 0;
	int samplesChecked = 0;
	e1fes_top dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .alignShiftEvent(ev[4]), .patternImitationEvent(ev[2]), .crc4ErrorEvent(ev[1]),
		.fasBitErrorEvent(ev[0]), .fasChecked, .fasErrored, .resyncDone, .frameLossDefect, .irqOut);
	e1fes_host_model host (.clk_sys, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samplesChecked++;
		if (s !== e) begin
			errTotal++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// an index outside the register map answers with an error response
	function automatic logic unmapped(input logic [11:0] i);
		return !(i inside {IDX_FRAMING_CTRL, IDX_EVENT_STATUS, IDX_EVENT_ENABLE, IDX_DEFECT_STATE});
	endfunction
	task automatic rd(input logic [11:0] i, input logic [31:0] e);
		expQ.push_back(e);
		slvErrQ.push_back(unmapped(i));
		host.xfer({2'h0, i, 2'h0}, 1'b0, 32'h00000000);
	endtask
	task automatic wr(input logic [11:0] i, input logic [31:0] d);
		slvErrQ.push_back(unmapped(i));
		host.xfer({2'h0, i, 2'h0}, 1'b1, d);
	endtask
	task automatic pulse(input logic [4:0] p);
		@(posedge clk_sys);
		ev <= p;
		@(posedge clk_sys);
		ev <= 5'h00;
	endtask
	task automatic frame_alignment_signal(input logic e);
		@(posedge clk_sys);
		fasChecked <= 1'b1;
		fasErrored <= e;
		@(posedge clk_sys);
		fasChecked <= 1'b0;
		fasErrored <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checked=%0d errors=%0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1)
			chk({31'h0, pslverr}, {31'h0, slvErrQ.pop_front()});
		if (psel && penable && !pwrite && pready === 1'b1)
			chk(prdata, expQ.pop_front());
	end
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#500000;
		errTotal++;
		report_and_stop();
	end
	initial begin
		{rst, ev, fasChecked, fasErrored, resyncDone} = {1'b1, 8'h00};
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd(IDX_EVENT_STATUS, 32'h0);
		rd(IDX_EVENT_ENABLE, 32'h0);
		rd(IDX_FRAMING_CTRL, 32'h3);
		for (int k = 0; k < 8; k++) begin
			m = (k == 0) ? 5'h17 : 5'(xs()) & 5'h17;
			pulse(m);
			rd(IDX_EVENT_STATUS, {27'h0, m});
			rd(IDX_EVENT_STATUS, 32'h0);
		end
		wr(IDX_FRAMING_CTRL, 32'h2);
		frame_alignment_signal(1'b1);
		frame_alignment_signal(1'b0);
		pulse(5'h01);
		rd(IDX_DEFECT_STATE, 32'h0);
		rd(IDX_EVENT_STATUS, 32'h1);
		frame_alignment_signal(1'b1);
		frame_alignment_signal(1'b1);
		repeat (2) @(posedge clk_sys);
		rd(IDX_DEFECT_STATE, 32'h1);
		chk({31'h0, frameLossDefect}, 32'h1);
		rd(IDX_EVENT_STATUS, 32'h8);
		@(posedge clk_sys) resyncDone <= 1'b1;
		@(posedge clk_sys) resyncDone <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rd(IDX_DEFECT_STATE, 32'h0);
		chk({31'h0, frameLossDefect}, 32'h0);
		rd(IDX_EVENT_STATUS, 32'h8);
		wr(IDX_EVENT_ENABLE, 32'h10);
		rd(IDX_EVENT_ENABLE, 32'h10);
		pulse(5'h04);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, irqOut}, 32'h0);
		pulse(5'h10);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, irqOut}, 32'h1);
		rd(IDX_EVENT_STATUS, 32'h14);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, irqOut}, 32'h0);
		fork
			rd(IDX_EVENT_STATUS, 32'h0);
			begin
				repeat (2) @(posedge clk_sys);
				ev <= 5'h02;
				@(posedge clk_sys);
				ev <= 5'h00;
			end
		join
		rd(IDX_EVENT_STATUS, 32'h2);
		rd(12'h001, 32'h0);
		wr(IDX_EVENT_STATUS, 32'hFF);
		rd(IDX_EVENT_STATUS, 32'h0);
		// reset in mid-run with a latched, enabled event and a changed threshold
		pulse(5'h11);
		@(posedge clk_sys) rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(IDX_EVENT_STATUS, 32'h0);
		rd(IDX_EVENT_ENABLE, 32'h0);
		rd(IDX_FRAMING_CTRL, 32'h3);
		chk({31'h0, irqOut}, 32'h0);
		report_and_stop();
	end
endmodule
